/* File: src/dcmt_pkg.sv */
`default_nettype none

package dcmt_pkg;

  // whole timer state, registered in one place
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] csr;
    logic [7:0] cntH;
    logic [7:0] cntL;
    logic [7:0] cmpH;
    logic [7:0] cmpL;
    logic irqReq;
    logic irqEn;
    logic [4:0] pre;
    logic evtPrev;
    logic pinH;
    logic pinL;
    logic [7:0] rdata;
    logic irq;
  } dcmt_state_t;

endpackage

`default_nettype wire

/* File: src/dcmt_regs.svh */
`ifndef DCMT_REGS_SVH
`define DCMT_REGS_SVH

// ==========================================================
// register addresses
`define DCMT_ADDR_CTRL 16'hFFB6
`define DCMT_ADDR_CSR 16'hFFB7
`define DCMT_ADDR_CNTH 16'hFFB8
`define DCMT_ADDR_CNTL 16'hFFB9
`define DCMT_ADDR_CMPH 16'hFFBA
`define DCMT_ADDR_CMPL 16'hFFBB
`define DCMT_ADDR_IEN2 16'hFFF4
`define DCMT_ADDR_IRR2 16'hFFF7

// ==========================================================
// timer_control fields
`define DCMT_HIGH_TOGGLE_LEVEL 7
`define DCMT_SELH_HI 6
`define DCMT_SELH_LO 4
`define DCMT_LOW_TOGGLE_LEVEL 3
`define DCMT_SELL_HI 2
`define DCMT_SELL_LO 0
`define DCMT_SEL_INT 2

// ==========================================================
// timer_control_status fields
`define DCMT_HIGH_OVERFLOW_FLAG 7
`define DCMT_HIGH_MATCH_FLAG 6
`define DCMT_HIGH_OVERFLOW_IRQ_ENABLE 5
`define DCMT_HIGH_CLEAR_ON_MATCH 4
`define DCMT_LOW_OVERFLOW_FLAG 3
`define DCMT_LOW_MATCH_FLAG 2
`define DCMT_LOW_OVERFLOW_IRQ_ENABLE 1
`define DCMT_LOW_CLEAR_ON_MATCH 0

// irq request / enable bit
`define DCMT_IRQ_TFL 2

// ==========================================================
// clock select codes and prescaler masks
`define DCMT_SEL_DIV32 3'h4
`define DCMT_SEL_DIV16 3'h5
`define DCMT_SEL_DIV4 3'h6
`define DCMT_SEL_DIV2 3'h7
`define DCMT_MASK_DIV32 5'h1F
`define DCMT_MASK_DIV16 5'h0F
`define DCMT_MASK_DIV4 5'h03
`define DCMT_MASK_DIV2 5'h01
`define DCMT_PRE_STEP 5'h01
`define DCMT_PRE_RST 5'h00

// ==========================================================
// reset values and constants
`define DCMT_CTRL_RST 8'h00
`define DCMT_CSR_RST 8'h00
`define DCMT_CNT_RST 8'h00
`define DCMT_CMP_RST 8'hFF
`define DCMT_BYTE_MAX 8'hFF
`define DCMT_BYTE_ZERO 8'h00
`define DCMT_BYTE_ONE 8'h01
`define DCMT_WORD_MAX 16'hFFFF
`define DCMT_WORD_ZERO 16'h0000
`define DCMT_WORD_ONE 16'h0001

`endif

/* File: src/dcmt_timer.sv */
// Functional notes
// - control picks 16/8-bit mode and count clocks
// - high select 110 counts at clock/4
// - low select 110 counts at clock/4
// - control bit7 sets high toggle pin level
// - control bit3 sets low toggle pin level
// - high wrap FF to 00 sets flag
// - high count equals compare sets flag
// - high overflow irq only when enabled
// - high clear-on-match bit clears counter
// - low wrap FF to 00 sets flag
// - low count equals compare sets flag
// - low overflow irq only when enabled
// - low clear-on-match gives repeating interval
// - low match requests irq; registers read/write
// - low request set by match, write-zero clear
// - low request passes only when enabled
`timescale 1ns/1ps
`default_nettype none
`include "dcmt_regs.svh"

module dcmt_timer (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [15:0] address,
  input wire logic [7:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [7:0] readData,
  input wire logic eventPin,
  output logic highTogglePin,
  output logic lowTogglePin,
  output logic irq
);

  dcmt_pkg::dcmt_state_t q;
  dcmt_pkg::dcmt_state_t d;

  // ==========================================================
  // address decode
  logic wrCtrl;
  logic wrCsr;
  logic wrCntH;
  logic wrCntL;
  logic wrCmpH;
  logic wrCmpL;
  logic wrIen;
  logic wrIrr;

  assign wrCtrl = writeStrobe && address == `DCMT_ADDR_CTRL;
  assign wrCsr = writeStrobe && address == `DCMT_ADDR_CSR;
  assign wrCntH = writeStrobe && address == `DCMT_ADDR_CNTH;
  assign wrCntL = writeStrobe && address == `DCMT_ADDR_CNTL;
  assign wrCmpH = writeStrobe && address == `DCMT_ADDR_CMPH;
  assign wrCmpL = writeStrobe && address == `DCMT_ADDR_CMPL;
  assign wrIen = writeStrobe && address == `DCMT_ADDR_IEN2;
  assign wrIrr = writeStrobe && address == `DCMT_ADDR_IRR2;

  // ==========================================================
  // count clock selection
  function automatic logic clkTick(
    input logic [2:0] sel,
    input logic [4:0] pre,
    input logic evt
  );
    logic t;
    t = evt;
    case (sel)
      `DCMT_SEL_DIV32: t = pre == `DCMT_MASK_DIV32;
      `DCMT_SEL_DIV16: t = (pre & `DCMT_MASK_DIV16) == `DCMT_MASK_DIV16;
      `DCMT_SEL_DIV4: t = (pre & `DCMT_MASK_DIV4) == `DCMT_MASK_DIV4;
      `DCMT_SEL_DIV2: t = (pre & `DCMT_MASK_DIV2) == `DCMT_MASK_DIV2;
      default: t = evt;
    endcase
    return t;
  endfunction

  logic [2:0] selH;
  logic [2:0] selL;
  logic mode16;
  logic evtEdge;
  logic tickH;
  logic tickL;

  assign selH = q.ctrl[`DCMT_SELH_HI:`DCMT_SELH_LO];
  assign selL = q.ctrl[`DCMT_SELL_HI:`DCMT_SELL_LO];
  // high select with the internal bit clear chains both halves
  assign mode16 = ~selH[`DCMT_SEL_INT];
  assign evtEdge = eventPin & ~q.evtPrev;
  assign tickL = clkTick(selL, q.pre, evtEdge);
  // in 8-bit mode the high half has its own clock
  assign tickH = ~mode16 & clkTick(selH, q.pre, evtEdge);

  // ==========================================================
  // count events
  logic [15:0] cnt16;
  logic [15:0] cmp16;
  logic match16;
  logic ovf16;
  logic matchH;
  logic matchL;
  logic high_overflow_flag;
  logic low_overflow_flag;

  assign cnt16 = {q.cntH, q.cntL};
  assign cmp16 = {q.cmpH, q.cmpL};
  assign match16 = mode16 && tickL && cnt16 == cmp16;
  assign ovf16 = mode16 && tickL && cnt16 == `DCMT_WORD_MAX
    && !(match16 && q.csr[`DCMT_HIGH_CLEAR_ON_MATCH]);
  // each half compares only against its own register
  assign matchH = tickH && q.cntH == q.cmpH;
  assign matchL = !mode16 && tickL && q.cntL == q.cmpL;
  assign high_overflow_flag = tickH && q.cntH == `DCMT_BYTE_MAX
    && !(matchH && q.csr[`DCMT_HIGH_CLEAR_ON_MATCH]);
  assign low_overflow_flag = !mode16 && tickL && q.cntL == `DCMT_BYTE_MAX
    && !(matchL && q.csr[`DCMT_LOW_CLEAR_ON_MATCH]);

  // ==========================================================
  // next state
  always_comb begin
    logic [15:0] n16;
    logic [7:0] flagClr;
    n16 = cnt16;
    flagClr = `DCMT_BYTE_ZERO;
    d = q;
    d.pre = q.pre + `DCMT_PRE_STEP;
    d.evtPrev = eventPin;

    // counters
    if (mode16) begin
      if (tickL) begin
        if (match16 && q.csr[`DCMT_HIGH_CLEAR_ON_MATCH]) begin
          n16 = `DCMT_WORD_ZERO;
        end else begin
          n16 = cnt16 + `DCMT_WORD_ONE;
        end
      end
      d.cntH = n16[15:8];
      d.cntL = n16[7:0];
    end else begin
      if (tickH) begin
        if (matchH && q.csr[`DCMT_HIGH_CLEAR_ON_MATCH]) begin
          d.cntH = `DCMT_BYTE_ZERO;
        end else begin
          d.cntH = q.cntH + `DCMT_BYTE_ONE;
        end
      end
      if (tickL) begin
        if (matchL && q.csr[`DCMT_LOW_CLEAR_ON_MATCH]) begin
          d.cntL = `DCMT_BYTE_ZERO;
        end else begin
          d.cntL = q.cntL + `DCMT_BYTE_ONE;
        end
      end
    end
    // software loads win over counting
    if (wrCntH) begin
      d.cntH = writeData;
    end
    if (wrCntL) begin
      d.cntL = writeData;
    end
    if (wrCmpH) begin
      d.cmpH = writeData;
    end
    if (wrCmpL) begin
      d.cmpL = writeData;
    end

    // toggle pins flip on match; a control write sets the level
    if (match16 || matchH) begin
      d.pinH = ~q.pinH;
    end
    if (matchL) begin
      d.pinL = ~q.pinL;
    end
    if (wrCtrl) begin
      d.ctrl = writeData;
      d.pinH = writeData[`DCMT_HIGH_TOGGLE_LEVEL];
      d.pinL = writeData[`DCMT_LOW_TOGGLE_LEVEL];
    end

    // status: flags clear on write of zero, a new event wins
    if (wrCsr) begin
      d.csr[`DCMT_HIGH_OVERFLOW_IRQ_ENABLE] = writeData[`DCMT_HIGH_OVERFLOW_IRQ_ENABLE];
      d.csr[`DCMT_HIGH_CLEAR_ON_MATCH] = writeData[`DCMT_HIGH_CLEAR_ON_MATCH];
      d.csr[`DCMT_LOW_OVERFLOW_IRQ_ENABLE] = writeData[`DCMT_LOW_OVERFLOW_IRQ_ENABLE];
      d.csr[`DCMT_LOW_CLEAR_ON_MATCH] = writeData[`DCMT_LOW_CLEAR_ON_MATCH];
      flagClr = ~writeData;
    end
    d.csr[`DCMT_HIGH_OVERFLOW_FLAG] = high_overflow_flag || ovf16
      || (q.csr[`DCMT_HIGH_OVERFLOW_FLAG] && !flagClr[`DCMT_HIGH_OVERFLOW_FLAG]);
    d.csr[`DCMT_HIGH_MATCH_FLAG] = matchH || match16
      || (q.csr[`DCMT_HIGH_MATCH_FLAG] && !flagClr[`DCMT_HIGH_MATCH_FLAG]);
    d.csr[`DCMT_LOW_OVERFLOW_FLAG] = low_overflow_flag
      || (q.csr[`DCMT_LOW_OVERFLOW_FLAG] && !flagClr[`DCMT_LOW_OVERFLOW_FLAG]);
    d.csr[`DCMT_LOW_MATCH_FLAG] = matchL
      || (q.csr[`DCMT_LOW_MATCH_FLAG] && !flagClr[`DCMT_LOW_MATCH_FLAG]);

    // low timer request, cleared by writing zero
    if (wrIen) begin
      d.irqEn = writeData[`DCMT_IRQ_TFL];
    end
    d.irqReq = matchL || (q.irqReq
      && !(wrIrr && !writeData[`DCMT_IRQ_TFL]));

    // one registered line for all enabled sources
    d.irq = (q.irqReq && q.irqEn)
      || (q.csr[`DCMT_HIGH_OVERFLOW_FLAG] && q.csr[`DCMT_HIGH_OVERFLOW_IRQ_ENABLE])
      || (q.csr[`DCMT_LOW_OVERFLOW_FLAG] && q.csr[`DCMT_LOW_OVERFLOW_IRQ_ENABLE]);

    // read data stands only in the cycle after the strobe
    d.rdata = `DCMT_BYTE_ZERO;
    if (readStrobe) begin
      unique case (address)
        `DCMT_ADDR_CTRL: d.rdata = q.ctrl;
        `DCMT_ADDR_CSR: d.rdata = q.csr;
        `DCMT_ADDR_CNTH: d.rdata = q.cntH;
        `DCMT_ADDR_CNTL: d.rdata = q.cntL;
        `DCMT_ADDR_CMPH: d.rdata = q.cmpH;
        `DCMT_ADDR_CMPL: d.rdata = q.cmpL;
        `DCMT_ADDR_IEN2: d.rdata[`DCMT_IRQ_TFL] = q.irqEn;
        `DCMT_ADDR_IRR2: d.rdata[`DCMT_IRQ_TFL] = q.irqReq;
        default: d.rdata = `DCMT_BYTE_ZERO;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      q.ctrl <= `DCMT_CTRL_RST;
      q.csr <= `DCMT_CSR_RST;
      q.cntH <= `DCMT_CNT_RST;
      q.cntL <= `DCMT_CNT_RST;
      q.cmpH <= `DCMT_CMP_RST;
      q.cmpL <= `DCMT_CMP_RST;
      q.irqReq <= 1'b0;
      q.irqEn <= 1'b0;
      q.pre <= `DCMT_PRE_RST;
      q.evtPrev <= 1'b0;
      q.pinH <= 1'b0;
      q.pinL <= 1'b0;
      q.rdata <= `DCMT_BYTE_ZERO;
      q.irq <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign readData = q.rdata;
  assign highTogglePin = q.pinH;
  assign lowTogglePin = q.pinL;
  assign irq = q.irq;

  // ==========================================================
  // assertions
  sequence lowMatchS;
    matchL && !wrCntL && !wrIrr;
  endsequence

  sequence lowEnabledS;
    q.irqReq && q.irqEn;
  endsequence

  highDiv4Gate_a: assert property (
    @(posedge clock) disable iff (!resetn)
    !mode16 && selH == `DCMT_SEL_DIV4
      && (q.pre & `DCMT_MASK_DIV4) != `DCMT_MASK_DIV4
      && !wrCntH |=> $stable(q.cntH))
    else $error("high half advanced off the clock/4 tick");

  lowDiv4Step_a: assert property (
    @(posedge clock) disable iff (!resetn)
    !mode16 && selL == `DCMT_SEL_DIV4
      && (q.pre & `DCMT_MASK_DIV4) == `DCMT_MASK_DIV4
      && !wrCntL && !wrCtrl && q.cntL != q.cmpL
      |=> q.cntL == $past(q.cntL) + `DCMT_BYTE_ONE)
    else $error("low half missed its clock/4 step");

  highPinLevel_a: assert property (
    @(posedge clock) disable iff (!resetn)
    wrCtrl |=> highTogglePin == $past(writeData[`DCMT_HIGH_TOGGLE_LEVEL]))
    else $error("high toggle pin not set from control");

  lowPinLevel_a: assert property (
    @(posedge clock) disable iff (!resetn)
    wrCtrl |=> lowTogglePin == $past(writeData[`DCMT_LOW_TOGGLE_LEVEL]))
    else $error("low toggle pin not set from control");

  highOvfFlag_a: assert property (
    @(posedge clock) disable iff (!resetn)
    tickH && q.cntH == `DCMT_BYTE_MAX && !q.csr[`DCMT_HIGH_CLEAR_ON_MATCH] && !wrCntH
      |=> q.csr[`DCMT_HIGH_OVERFLOW_FLAG] && q.cntH == `DCMT_BYTE_ZERO)
    else $error("high wrap did not set its flag");

  highMatchFlag_a: assert property (
    @(posedge clock) disable iff (!resetn)
    tickH && q.cntH == q.cmpH |=> q.csr[`DCMT_HIGH_MATCH_FLAG])
    else $error("high match flag not set");

  ovfIrqGate_a: assert property (
    @(posedge clock) disable iff (!resetn)
    !q.csr[`DCMT_HIGH_OVERFLOW_IRQ_ENABLE] && !q.csr[`DCMT_LOW_OVERFLOW_IRQ_ENABLE]
      && !(q.irqReq && q.irqEn) |=> !irq)
    else $error("interrupt raised with sources disabled");

  highClear_a: assert property (
    @(posedge clock) disable iff (!resetn)
    tickH && q.csr[`DCMT_HIGH_CLEAR_ON_MATCH] && q.cntH == q.cmpH && !wrCntH
      |=> q.cntH == `DCMT_BYTE_ZERO)
    else $error("high counter not cleared on match");

  lowOvfFlag_a: assert property (
    @(posedge clock) disable iff (!resetn)
    low_overflow_flag && !wrCntL
      |=> q.csr[`DCMT_LOW_OVERFLOW_FLAG] && q.cntL == `DCMT_BYTE_ZERO)
    else $error("low wrap did not set its flag");

  lowMatchFlag_a: assert property (
    @(posedge clock) disable iff (!resetn)
    lowMatchS |=> q.csr[`DCMT_LOW_MATCH_FLAG])
    else $error("low match flag not set");

  lowOvfIrq_a: assert property (
    @(posedge clock) disable iff (!resetn)
    q.csr[`DCMT_LOW_OVERFLOW_FLAG] && q.csr[`DCMT_LOW_OVERFLOW_IRQ_ENABLE] |=> irq)
    else $error("enabled low overflow gave no interrupt");

  lowClear_a: assert property (
    @(posedge clock) disable iff (!resetn)
    lowMatchS and (q.csr[`DCMT_LOW_CLEAR_ON_MATCH] == 1'b1)
      |=> q.cntL == `DCMT_BYTE_ZERO)
    else $error("low counter not cleared on match");

  lowIrqSet_a: assert property (
    @(posedge clock) disable iff (!resetn)
    lowMatchS |=> q.irqReq)
    else $error("low match raised no request");

  lowReqClear_a: assert property (
    @(posedge clock) disable iff (!resetn)
    wrIrr && !writeData[`DCMT_IRQ_TFL] && !matchL |=> !q.irqReq)
    else $error("request not cleared by writing zero");

  lowIrqPath_a: assert property (
    @(posedge clock) disable iff (!resetn)
    lowEnabledS |=> irq)
    else $error("enabled low request did not reach irq");

  lowIrqMasked_a: assert property (
    @(posedge clock) disable iff (!resetn)
    lowMatchS ##1 (!q.irqEn && !q.csr[`DCMT_HIGH_OVERFLOW_IRQ_ENABLE]
      && !q.csr[`DCMT_LOW_OVERFLOW_IRQ_ENABLE]) |=> !irq)
    else $error("masked low request reached irq");

  readTiming_a: assert property (
    @(posedge clock) disable iff (!resetn)
    readStrobe && address == `DCMT_ADDR_CMPL
      |=> readData == $past(q.cmpL)
      ##1 ($past(readStrobe) || readData == `DCMT_BYTE_ZERO))
    else $error("read data not held for exactly one cycle");

  halvesApart_a: assert property (
    @(posedge clock) disable iff (!resetn)
    !mode16 && !tickL && !wrCntL |=> $stable(q.cntL))
    else $error("low half moved without its own tick");

endmodule

`default_nettype wire

/* File: testbench/tb_dual_8bit_compare_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dcmt_regs.svh"

module tb_dual_8bit_compare_timer;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] address = 16'h0000;
  logic [7:0] writeData = 8'h00;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  logic eventPin = 1'b0;
  logic [7:0] readData;
  logic highTogglePin;
  logic lowTogglePin;
  logic irq;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h0001_5012;

  dcmt_timer uut (
    .clock(clock),
    .resetn(resetn),
    .address(address),
    .writeData(writeData),
    .writeStrobe(writeStrobe),
    .readStrobe(readStrobe),
    .readData(readData),
    .eventPin(eventPin),
    .highTogglePin(highTogglePin),
    .lowTogglePin(lowTogglePin),
    .irq(irq)
  );

  always #2 clock = ~clock;

  // whole run is well under a thousand cycles; the ceiling only catches hangs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      bad_count = bad_count + 1;
      $display("ERROR at %0t: run did not finish", $time);
      summarize();
    end
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // a compare of c with clear-on-match repeats every c+1 ticks of clock/4
  function automatic logic [7:0] expPeriod(input logic [7:0] c);
    return (c + 8'h01) << 2;
  endfunction

  task automatic rnd(output logic [7:0] v);
    seed = lfsr(seed);
    v = seed[7:0];
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chkr(input logic [7:0] got, input logic [7:0] lo,
                      input logic [7:0] hi, input string what);
    comparisons++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      bad_count++;
      $display("ERROR at %0t: %s got %h outside %h..%h", $time, what, got,
               lo, hi);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1;
    d = readData;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic waitIrq(input logic val);
    int k;
    k = 0;
    while (irq !== val && k < 200) begin
      @(posedge clock);
      #1;
      k++;
    end
    chk({7'h00, irq}, {7'h00, val}, "irq wait");
  endtask

  // ==========================================================
  // tests
  logic [15:0] rstAddr [8] = '{`DCMT_ADDR_CTRL, `DCMT_ADDR_CSR,
    `DCMT_ADDR_CNTH, `DCMT_ADDR_CNTL, `DCMT_ADDR_CMPH, `DCMT_ADDR_CMPL,
    `DCMT_ADDR_IEN2, 16'hFFB0};
  logic [7:0] rstVal [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF,
    8'h00, 8'h00};
  logic [7:0] pinCtrl [4] = '{8'h88, 8'h80, 8'h08, 8'h00};
  logic [7:0] rateCtrl [4] = '{8'h66, 8'h76, 8'h46, 8'h56};
  logic [7:0] rateHlo [4] = '{8'h0A, 8'h15, 8'h01, 8'h02};
  logic [7:0] en [2] = '{8'h20, 8'h02};
  logic [7:0] d;
  logic [7:0] v;
  logic [7:0] cmp;
  int t1;

  initial begin
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(rstAddr[i], d);
      chk(d, rstVal[i], "reset value");
    end
    chk({5'h00, highTogglePin, lowTogglePin, irq}, 8'h00, "reset pins");
    wr(16'hFFB0, 8'hFF);
    rd(16'hFFB0, d);
    chk(d, 8'h00, "unmapped write ignored");
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      rnd(v);
      wr(`DCMT_ADDR_CMPL, v);
      rd(`DCMT_ADDR_CMPL, d);
      chk(d, v, "low compare readback");
      wr(`DCMT_ADDR_CMPH, ~v);
      rd(`DCMT_ADDR_CMPH, d);
      chk(d, ~v, "high compare readback");
    end
    wr(`DCMT_ADDR_CMPH, 8'hFF);
    wr(`DCMT_ADDR_CMPL, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      wr(`DCMT_ADDR_CTRL, pinCtrl[i]);
      settle(2);
      chk({6'h00, highTogglePin, lowTogglePin},
          {6'h00, pinCtrl[i][7], pinCtrl[i][3]}, "toggle pins");
    end
    $display("register test done");
    wr(`DCMT_ADDR_CTRL, 8'h60);
    wr(`DCMT_ADDR_CNTL, 8'h00);
    repeat (5) begin
      @(posedge clock);
      eventPin <= 1'b1;
      repeat (2) @(posedge clock);
      eventPin <= 1'b0;
      repeat (2) @(posedge clock);
    end
    rd(`DCMT_ADDR_CNTL, d);
    chk(d, 8'h05, "event count");
    for (int i = 0; i < 4; i++) begin
      wr(`DCMT_ADDR_CTRL, rateCtrl[i]);
      wr(`DCMT_ADDR_CNTH, 8'h00);
      wr(`DCMT_ADDR_CNTL, 8'h00);
      settle(40);
      rd(`DCMT_ADDR_CNTH, d);
      chkr(d, rateHlo[i], rateHlo[i] + 8'h02, "high rate");
      rd(`DCMT_ADDR_CNTL, d);
      chkr(d, 8'h0A, 8'h0C, "low rate");
    end
    wr(`DCMT_ADDR_CTRL, 8'h06);
    wr(`DCMT_ADDR_CNTH, 8'h00);
    wr(`DCMT_ADDR_CNTL, 8'hFE);
    settle(20);
    rd(`DCMT_ADDR_CNTH, d);
    chk(d, 8'h01, "cascade carry");
    $display("count test done");
    for (int i = 0; i < 3; i++) begin
      rnd(v);
      cmp = {5'h00, v[2:0]} | 8'h01;
      wr(`DCMT_ADDR_CTRL, 8'h66);
      wr(`DCMT_ADDR_CMPL, cmp);
      wr(`DCMT_ADDR_CNTL, 8'h00);
      wr(`DCMT_ADDR_CSR, 8'h01);
      wr(`DCMT_ADDR_IEN2, 8'h04);
      wr(`DCMT_ADDR_IRR2, 8'h00);
      waitIrq(1'b1);
      wr(`DCMT_ADDR_IRR2, 8'h00);
      waitIrq(1'b0);
      waitIrq(1'b1);
      t1 = cyc;
      wr(`DCMT_ADDR_IRR2, 8'h00);
      waitIrq(1'b0);
      waitIrq(1'b1);
      chk(8'(cyc - t1), expPeriod(cmp), "match period");
      rd(`DCMT_ADDR_CSR, d);
      chk(d, 8'h05, "low match flag");
    end
    wr(`DCMT_ADDR_IEN2, 8'h00);
    wr(`DCMT_ADDR_IRR2, 8'h00);
    settle(40);
    chk({7'h00, irq}, 8'h00, "masked irq");
    rd(`DCMT_ADDR_IRR2, d);
    chk(d, 8'h04, "request while masked");
    wr(`DCMT_ADDR_IEN2, 8'h04);
    settle(2);
    chk({7'h00, irq}, 8'h01, "unmasked irq");
    wr(`DCMT_ADDR_IEN2, 8'h00);
    wr(`DCMT_ADDR_IRR2, 8'h00);
    $display("interval test done");
    wr(`DCMT_ADDR_CTRL, 8'h77);
    wr(`DCMT_ADDR_CMPH, 8'h02);
    wr(`DCMT_ADDR_CMPL, 8'h02);
    wr(`DCMT_ADDR_CNTH, 8'hFA);
    wr(`DCMT_ADDR_CNTL, 8'hFA);
    wr(`DCMT_ADDR_CSR, 8'h00);
    settle(40);
    chk({7'h00, irq}, 8'h00, "overflow irq off");
    rd(`DCMT_ADDR_CSR, d);
    chk(d, 8'hCC, "wrap and match flags");
    rd(`DCMT_ADDR_CNTH, d);
    chkr(d, 8'h03, 8'h20, "high counts past match");
    for (int i = 0; i < 2; i++) begin
      wr(`DCMT_ADDR_CSR, 8'hCC | en[i]);
      settle(2);
      chk({7'h00, irq}, 8'h01, "overflow irq on");
      wr(`DCMT_ADDR_CSR, 8'hCC);
      settle(2);
      chk({7'h00, irq}, 8'h00, "overflow irq gated");
    end
    wr(`DCMT_ADDR_CTRL, 8'h00);
    wr(`DCMT_ADDR_CSR, 8'h00);
    wr(`DCMT_ADDR_IRR2, 8'h00);
    rd(`DCMT_ADDR_CSR, d);
    chk(d, 8'h00, "flags cleared by zero");
    $display("overflow test done");
    wr(`DCMT_ADDR_CTRL, 8'h66);
    wr(`DCMT_ADDR_CMPH, 8'h03);
    wr(`DCMT_ADDR_CSR, 8'h10);
    wr(`DCMT_ADDR_CNTH, 8'h00);
    repeat (8) begin
      rd(`DCMT_ADDR_CNTH, d);
      chkr(d, 8'h00, 8'h03, "high clear on match");
    end
    $display("clear test done");
    summarize();
  end
endmodule

`default_nettype wire
